// File: core/cfd_timing_regs.sv
// Operation
// [R01] endianness register returns fixed pattern
// [R02] scratch word, read/write, no effect
// [R03] data timing writable only with cce and init
// [R04] bit 4..25 tq, tq 1..32 clocks; code allows 3..49 tq (5-bit seg1, 4-bit seg2)
// [R05] tq equals clock times prescaler plus one
// [R06] bit length seg1 plus seg2 plus three
// [R07] seg1 lasts tq times value plus one
// [R08] seg2 lasts tq times value plus one
// [R09] jump width tq times value plus one
// [R10] next bit data ready right after sample
// [R11] software keeps data rate at least nominal
// [R12] bit 23 enables delay compensation
// [R13] data timing resets to default
// [R14] test register writable only in test mode
// [R15] leaving test mode resets test functions
// [R16] bit 7 shows live receive pin
// [R17] transmit pin mode field selects pin source
// [R18] bit 4 enables internal loop back
// [R19] ram access or ready reloads watchdog
// [R20] watchdog expiry stops counter, sets flag
// [R21] watchdog off when start value zero
// [R22] bit 15 selects pre-standard fd format
// [R23] transmit pause two bits after success
// [R24] init set at reset, bus untouched
// [R25] protected bits need cce and init
// [R26] reserved bits read zero, ignore writes
module cfd_timing_regs (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // protocol core side
  input  wire logic        i_core_tx_bit,
  input  wire logic        i_tx_success,
  output logic             o_core_rx_bit,
  output logic             o_sample_point,
  output logic             o_bit_end,
  output logic             o_tx_pause_active,
  output logic             o_init,
  output logic             o_config_change_enable,
  output logic             o_pre_standard_fd_format,
  output logic             o_delay_compensation_enable,
  // message ram side
  input  wire logic        i_ram_access,
  input  wire logic        i_ram_ready,
  output logic             o_ram_watchdog_flag,
  // can pins
  input  wire logic        i_bus_receive_pin,
  output logic             o_bus_transmit_pin
);
  import cfd_pkg::*;

  logic [31:0] scratch_value_ff;
  logic [31:0] data_time_ff;
  logic [1:0]  tx_mode_ff;
  logic        loop_back_enable_ff;
  logic        rx_pin_ff;
  logic [7:0]  ram_watchdog_start_value_ff;
  logic [7:0]  ram_watchdog_count_ff;
  logic        wd_run_ff;
  logic        ram_watchdog_flag_ff;
  logic        init_ff;
  logic        config_change_enable_ff;
  logic        test_enable_ff;
  logic        transmit_pause_enable_ff;
  logic        pre_standard_fd_format_ff;
  logic [4:0]  tq_cnt_ff;
  logic [5:0]  tq_idx_ff;
  logic        rx_prev_ff;
  logic        core_bit_ff;
  logic [1:0]  pause_cnt_ff;
  logic        pause_active_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        tx_pin_ff;
  logic        core_rx_ff;
  logic        sample_ff;
  logic        bit_end_ff;

  // field extraction
  function automatic logic [4:0] field5(input logic [31:0] w, input int lo);
    field5 = w[lo +: 5];
  endfunction

  // apb decode
  wire         acc       = psel & penable & pready_ff;
  wire         wr        = acc & pwrite;
  // first access cycle, answered at the next edge
  wire         acc_first = psel & penable & ~pready_ff;
  wire         hit_end   = (paddr == ADDR_ENDIAN);
  wire         hit_scr   = (paddr == ADDR_SCRATCH);
  wire         hit_dt    = (paddr == ADDR_DATA_TIME);
  wire         hit_tst   = (paddr == ADDR_TEST);
  wire         hit_wd    = (paddr == ADDR_WATCHDOG);
  wire         hit_cc    = (paddr == ADDR_CORE_CTRL);
  wire         mapped    = hit_end | hit_scr | hit_dt | hit_tst | hit_wd | hit_cc;
  wire         protect_ok = config_change_enable_ff & init_ff; // [R25]
  wire         wr_dt     = wr & hit_dt & protect_ok;           // [R03]
  wire         wr_tst    = wr & hit_tst & test_enable_ff;      // [R14]
  wire         wr_wd     = wr & hit_wd;
  wire         wr_cc     = wr & hit_cc;
  wire         wr_scr    = wr & hit_scr;

  // timing fields
  wire [4:0]   prescale  = field5(data_time_ff, DT_PRE_LO);   // [R05]
  wire [4:0]   seg1      = field5(data_time_ff, DT_SEG1_LO);
  wire [3:0]   seg2      = data_time_ff[DT_SEG2_HI:DT_SEG2_LO];
  wire [2:0]   sjw       = data_time_ff[DT_SJW_HI:DT_SJW_LO];
  // last tq index of the bit: seg1 + seg2 + 3 quanta in all
  wire [5:0]   bit_last  = 6'(seg1) + 6'(seg2) + 6'(BIT_FIXED_TQ) - 6'd1; // [R06] [R04]
  wire         tq_tick   = ~init_ff & (tq_cnt_ff == prescale);
  // sample point closes the sync quantum plus seg1 + 1 quanta
  wire [5:0]   sample_idx = 6'(seg1) + 6'd1;                   // [R07]
  wire         at_sample = tq_tick & (tq_idx_ff == sample_idx); // [R07]
  wire [5:0]   tq_left   = bit_last - tq_idx_ff;
  wire         rx_fall   = rx_prev_ff & ~i_bus_receive_pin;
  // edge in phase after sample point shortens bit, bounded by jump width
  wire         resync    = rx_fall & ~init_ff & (tq_idx_ff > sample_idx) // [R09]
                           & (tq_left <= 6'(sjw) + 6'd1);
  wire         at_end    = (tq_tick & (tq_idx_ff == bit_last)) | resync; // [R08]

  // watchdog
  wire         wd_on     = (ram_watchdog_start_value_ff != 8'h00); // [R21]
  wire         wd_expire = wd_run_ff & (ram_watchdog_count_ff == 8'h01);
  // ram answer beats expiry, clear loses to expiry
  wire         wd_answer = i_ram_ready | i_ram_access;
  wire         wd_clear  = wr_wd & pwdata[WD_FLAG_BIT];

  // transmit pause, counted in data bit ends
  wire         pause_load = i_tx_success & transmit_pause_enable_ff;
  wire         pause_step = at_end & (pause_cnt_ff != 2'd0);

  // read mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000; // [R26]
    if (hit_end) begin
      rd_word = BYTE_ORDER_PATTERN; // [R01]
    end else if (hit_scr) begin
      rd_word = scratch_value_ff;
    end else if (hit_dt) begin
      rd_word = data_time_ff;
    end else if (hit_tst) begin
      rd_word[TST_RX_BIT]            = rx_pin_ff; // [R16]
      rd_word[TST_TX_HI:TST_TX_LO]   = tx_mode_ff;
      rd_word[TST_LBK_BIT]           = loop_back_enable_ff;
    end else if (hit_wd) begin
      rd_word[7:0]                   = ram_watchdog_start_value_ff;
      rd_word[WD_CNT_LO +: 8]        = ram_watchdog_count_ff;
      rd_word[WD_FLAG_BIT]           = ram_watchdog_flag_ff;
    end else if (hit_cc) begin
      rd_word[CC_INIT_BIT]           = init_ff;
      rd_word[CC_CCE_BIT]            = config_change_enable_ff;
      rd_word[CC_TEST_BIT]           = test_enable_ff;
      rd_word[CC_TXP_BIT]            = transmit_pause_enable_ff;
      rd_word[CC_PRE_STANDARD_FD_FORMAT_BIT]           = pre_standard_fd_format_ff;
    end
  end

  // pin source select
  logic nxt_tx_pin;
  always_comb begin
    case (tx_mode_ff) // [R17]
      CFD_TX_CORE:     nxt_tx_pin = core_bit_ff;
      CFD_TX_SAMPLE:   nxt_tx_pin = at_sample;
      CFD_TX_DOMINANT: nxt_tx_pin = 1'b0;
      CFD_TX_RECESS:   nxt_tx_pin = 1'b1;
      default:         nxt_tx_pin = 1'b1;
    endcase
    if (init_ff && tx_mode_ff == CFD_TX_CORE) begin
      nxt_tx_pin = 1'b1; // [R24]
    end
  end

  // apb handshake, one wait state
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= acc_first;
      pslverr_ff <= acc_first & ~mapped;
      prdata_ff  <= (acc_first & ~pwrite) ? rd_word : 32'h00000000;
    end
  end

  // scratch and data timing registers
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scratch_value_ff <= SCRATCH_RESET;   // [R02]
      data_time_ff     <= DATA_TIME_RESET; // [R13] [R12]
    end else begin
      if (wr_scr) begin
        scratch_value_ff <= pwdata; // [R02]
      end
      if (wr_dt) begin
        data_time_ff <= pwdata & DATA_TIME_MASK; // [R26]
      end
    end
  end

  // core control
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      init_ff                   <= 1'b1; // [R24]
      config_change_enable_ff   <= 1'b0;
      test_enable_ff            <= 1'b0;
      transmit_pause_enable_ff  <= 1'b0;
      pre_standard_fd_format_ff <= 1'b0; // [R22]
    end else if (wr_cc) begin
      init_ff <= pwdata[CC_INIT_BIT];
      // cce only while init stays set
      config_change_enable_ff <= pwdata[CC_CCE_BIT] & pwdata[CC_INIT_BIT] & init_ff;
      if (protect_ok) begin
        transmit_pause_enable_ff  <= pwdata[CC_TXP_BIT];  // [R25]
        pre_standard_fd_format_ff <= pwdata[CC_PRE_STANDARD_FD_FORMAT_BIT]; // [R22]
        test_enable_ff            <= pwdata[CC_TEST_BIT];
      end else if (!pwdata[CC_TEST_BIT]) begin
        test_enable_ff <= 1'b0; // clearing is never protected
      end
    end
  end

  // test register
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_mode_ff          <= CFD_TX_CORE;
      loop_back_enable_ff <= 1'b0; // [R18]
      rx_pin_ff           <= 1'b1;
    end else begin
      rx_pin_ff <= i_bus_receive_pin; // [R16]
      if (!test_enable_ff) begin
        tx_mode_ff          <= CFD_TX_CORE; // [R15]
        loop_back_enable_ff <= 1'b0;
      end else if (wr_tst) begin
        tx_mode_ff          <= pwdata[TST_TX_HI:TST_TX_LO];
        loop_back_enable_ff <= pwdata[TST_LBK_BIT]; // [R18]
      end
    end
  end

  // ram watchdog
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ram_watchdog_start_value_ff <= 8'h00;
      ram_watchdog_count_ff       <= 8'h00;
      wd_run_ff                   <= 1'b0;
      ram_watchdog_flag_ff        <= 1'b0;
    end else begin
      if (wr_wd) begin
        ram_watchdog_start_value_ff <= pwdata[7:0];
      end
      if (i_ram_ready) begin
        ram_watchdog_count_ff <= ram_watchdog_start_value_ff; // [R19]
        wd_run_ff             <= 1'b0;
      end else if (i_ram_access) begin
        ram_watchdog_count_ff <= ram_watchdog_start_value_ff; // [R19]
        wd_run_ff             <= wd_on; // [R21]
      end else if (wd_run_ff) begin
        ram_watchdog_count_ff <= ram_watchdog_count_ff - 8'h01;
        wd_run_ff             <= ~wd_expire; // [R20]
      end
      // set wins over a clear in the same cycle
      if (wd_expire && !wd_answer) begin
        ram_watchdog_flag_ff <= 1'b1; // [R20]
      end else if (wd_clear) begin
        ram_watchdog_flag_ff <= 1'b0;
      end
    end
  end

  // data bit timing generator
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tq_cnt_ff  <= 5'd0;
      tq_idx_ff  <= 6'd0;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_prev_ff <= i_bus_receive_pin;
      if (init_ff || at_end) begin
        tq_cnt_ff <= 5'd0;
        tq_idx_ff <= 6'd0;
      end else if (tq_tick) begin
        tq_cnt_ff <= 5'd0;              // [R05]
        tq_idx_ff <= tq_idx_ff + 6'd1;
      end else begin
        tq_cnt_ff <= tq_cnt_ff + 5'd1;
      end
    end
  end

  // core bit, pause and pins
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_bit_ff  <= 1'b1;
      pause_cnt_ff <= 2'd0;
      pause_active_ff <= 1'b0;
      tx_pin_ff    <= 1'b1; // [R24]
      core_rx_ff   <= 1'b1;
      sample_ff    <= 1'b0;
      bit_end_ff   <= 1'b0;
    end else begin
      if (at_end) begin
        core_bit_ff <= i_core_tx_bit; // [R17]
      end
      if (pause_load) begin
        pause_cnt_ff <= PAUSE_BITS; // [R23]
      end else if (pause_step) begin
        pause_cnt_ff <= pause_cnt_ff - 2'd1; // [R23]
      end
      pause_active_ff <= (pause_cnt_ff != 2'd0);
      tx_pin_ff   <= nxt_tx_pin;
      core_rx_ff  <= loop_back_enable_ff ? core_bit_ff : i_bus_receive_pin; // [R18]
      sample_ff   <= at_sample; // [R10]
      bit_end_ff  <= at_end;
    end
  end

  // outputs
  assign prdata                      = prdata_ff;
  assign pready                      = pready_ff;
  assign pslverr                     = pslverr_ff;
  assign o_bus_transmit_pin          = tx_pin_ff;
  assign o_core_rx_bit               = core_rx_ff;
  assign o_sample_point              = sample_ff;
  assign o_bit_end                   = bit_end_ff;
  assign o_tx_pause_active           = pause_active_ff;
  assign o_init                      = init_ff;
  assign o_config_change_enable      = config_change_enable_ff;
  assign o_pre_standard_fd_format    = pre_standard_fd_format_ff;
  assign o_delay_compensation_enable = data_time_ff[DT_TDC_BIT]; // [R12]
  assign o_ram_watchdog_flag         = ram_watchdog_flag_ff;

endmodule

// File: core/cfd_pkg.sv
package cfd_pkg;
  // register byte offsets
  localparam logic [7:0]  ADDR_ENDIAN    = 8'h04;
  localparam logic [7:0]  ADDR_SCRATCH   = 8'h08;
  localparam logic [7:0]  ADDR_DATA_TIME = 8'h0C;
  localparam logic [7:0]  ADDR_TEST      = 8'h10;
  localparam logic [7:0]  ADDR_WATCHDOG  = 8'h14;
  localparam logic [7:0]  ADDR_CORE_CTRL = 8'h18;
  // reset values and constants
  localparam logic [31:0] BYTE_ORDER_PATTERN = 32'h87654321;
  localparam logic [31:0] SCRATCH_RESET      = 32'h00000000;
  localparam logic [31:0] DATA_TIME_RESET    = 32'h00000A33;
  // data timing fields
  localparam int DT_TDC_BIT  = 23;
  localparam int DT_PRE_HI   = 20;
  localparam int DT_PRE_LO   = 16;
  localparam int DT_SEG1_HI  = 12;
  localparam int DT_SEG1_LO  = 8;
  localparam int DT_SEG2_HI  = 7;
  localparam int DT_SEG2_LO  = 4;
  localparam int DT_SJW_HI   = 2;
  localparam int DT_SJW_LO   = 0;
  localparam logic [31:0] DATA_TIME_MASK = 32'h009F1FF7;
  // test register fields
  localparam int TST_RX_BIT  = 7;
  localparam int TST_TX_HI   = 6;
  localparam int TST_TX_LO   = 5;
  localparam int TST_LBK_BIT = 4;
  // watchdog register fields
  localparam int WD_CNT_LO   = 8;
  localparam int WD_FLAG_BIT = 16;
  // core control fields
  localparam int CC_INIT_BIT = 0;
  localparam int CC_CCE_BIT  = 1;
  localparam int CC_TEST_BIT = 7;
  localparam int CC_TXP_BIT  = 14;
  localparam int CC_PRE_STANDARD_FD_FORMAT_BIT = 15;
  // timing
  localparam logic [4:0]  BIT_FIXED_TQ = 5'd3;
  localparam logic [1:0]  PAUSE_BITS   = 2'd2;
  // transmit pin modes
  typedef enum logic [1:0] {
    CFD_TX_CORE     = 2'b00,
    CFD_TX_SAMPLE   = 2'b01,
    CFD_TX_DOMINANT = 2'b10,
    CFD_TX_RECESS   = 2'b11
  } cfd_tx_mode_e;
endpackage

// File: tb/cfd_timing_regs_assertions.sv
module cfd_timing_regs_assertions
  import cfd_pkg::*;
(
  // bus
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // core and ram
  input wire logic        o_sample_point,
  input wire logic        o_bit_end,
  input wire logic        o_init,
  input wire logic        o_config_change_enable,
  input wire logic        i_ram_access,
  input wire logic        i_ram_ready,
  input wire logic        o_ram_watchdog_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // bus answers after one wait state
  a_bus_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_endian_fixed: assert property (
    pready && !pwrite && paddr == ADDR_ENDIAN |-> prdata == BYTE_ORDER_PATTERN)
    else $error("endian word wrong");
  a_unmapped_zero: assert property (
    pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_cce_init: assert property (o_config_change_enable |-> o_init)
    else $error("cce without init");
  // watchdog flag never set on a ram answer, only cleared by write
  a_flag_clear: assert property (
    $fell(o_ram_watchdog_flag) |->
      $past(pready && pwrite && paddr == ADDR_WATCHDOG && pwdata[WD_FLAG_BIT]))
    else $error("flag cleared by itself");
  a_flag_cause: assert property (
    $rose(o_ram_watchdog_flag) |-> $past(!i_ram_ready && !i_ram_access))
    else $error("flag despite ram answer");
  // bit generator quiet in init, pulses spaced
  a_init_idle: assert property (
    o_init && $past(o_init) && $past(o_init, 2) |-> !o_bit_end && !o_sample_point)
    else $error("bit timing runs in init");
  a_bit_apart: assert property (o_bit_end |=> !o_bit_end [*2])
    else $error("bit too short");
  c_flag: cover property ($rose(o_ram_watchdog_flag));
  c_bit: cover property (o_bit_end);
  c_err: cover property (pslverr);
endmodule

bind cfd_timing_regs cfd_timing_regs_assertions u_chk (
  .i_clock, .i_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .o_sample_point, .o_bit_end, .o_init, .o_config_change_enable,
  .i_ram_access, .i_ram_ready, .o_ram_watchdog_flag);

// File: tb/cfd_bus_model.sv
module cfd_bus_model (
  // clock and speed select
  input  wire logic i_clock,
  input  wire logic i_slow,
  // transceiver pins
  input  wire logic i_bus_transmit_pin,
  output logic      o_bus_receive_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] dly_ff = 4'hF;
  // loop delay of the transceiver, bus idles recessive
  always_ff @(posedge i_clock) dly_ff <= {dly_ff[2:0], i_bus_transmit_pin};
  assign o_bus_receive_pin = i_slow ? dly_ff[3] : dly_ff[0];
endmodule

// File: tb/cfd_timing_regs_test.sv
module cfd_timing_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import cfd_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_reset_n, psel, penable, pwrite, slow, i_core_tx_bit, i_tx_success;
  logic        i_ram_access, i_ram_ready, pready, pslverr, rx_pin, tx_pin, core_rx;
  logic        bit_end, pause, fmt, delay_compensation_enable, flag, smp, init, cce;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          miscompares = 0;
  int          num_checks = 0;

  cfd_timing_regs u_dut (
    .i_clock, .i_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .i_core_tx_bit, .i_tx_success, .o_core_rx_bit(core_rx), .o_sample_point(smp),
    .o_bit_end(bit_end), .o_tx_pause_active(pause), .o_init(init), .o_config_change_enable(cce),
    .o_pre_standard_fd_format(fmt), .o_delay_compensation_enable(delay_compensation_enable), .i_ram_access,
    .i_ram_ready, .o_ram_watchdog_flag(flag), .i_bus_receive_pin(rx_pin),
    .o_bus_transmit_pin(tx_pin));
  cfd_bus_model u_bus (.i_clock, .i_slow(slow), .i_bus_transmit_pin(tx_pin),
    .o_bus_receive_pin(rx_pin));

  always #2.5 i_clock = ~i_clock;

  task automatic conclude;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // one apb transfer, then an idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      conclude();
    end
    @(posedge i_clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, a, d, q, e);
  endtask
  task automatic cc(input logic [31:0] d);
    wr(ADDR_CORE_CTRL, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] q;
    logic e;
    bus(1'b0, a, 32'h0, q, e);
    chk($sformatf("reg %h", a), x, q & m);
  endtask
  // one-cycle pulse: 0 ram access, 1 ram ready, 2 tx success
  task automatic pulse(input int k);
    if (k == 0) i_ram_access <= 1'b1;
    else if (k == 1) i_ram_ready <= 1'b1;
    else i_tx_success <= 1'b1;
    @(posedge i_clock);
    i_ram_access <= 1'b0;
    i_ram_ready <= 1'b0;
    i_tx_success <= 1'b0;
    @(posedge i_clock);
  endtask
  // clocks between two bit ends, and from bit end to sample point
  task automatic period(input int x, input int s);
    int n;
    int p;
    n = 0;
    p = 0;
    do @(posedge i_clock); while (bit_end !== 1'b1 && ++n < 100);
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
      if (smp === 1'b1) p = n;
    end while (bit_end !== 1'b1 && n < 100);
    chk("bit period", x, n);
    chk("sample point", s, p);
  endtask
  task automatic pause_len(input int lo, input int hi);
    int k;
    k = 0;
    pulse(2);
    repeat (40) begin
      @(posedge i_clock);
      if (pause === 1'b1) k++;
    end
    chk("pause length", 1, k >= lo && k <= hi);
  endtask

  task automatic t_reset;
    rd(ADDR_ENDIAN, BYTE_ORDER_PATTERN);
    rd(ADDR_SCRATCH, SCRATCH_RESET);
    rd(ADDR_DATA_TIME, DATA_TIME_RESET);
    rd(ADDR_TEST, 32'h0, 32'hFFFFFF7F);
    rd(ADDR_WATCHDOG, 32'h0);
    rd(ADDR_CORE_CTRL, 32'h1);
    chk("tx pin", 1, tx_pin);
    chk("init", 1, init);
    chk("tdc", 0, delay_compensation_enable);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    wr(ADDR_SCRATCH, 32'hA5C30F96);
    rd(ADDR_SCRATCH, 32'hA5C30F96);
    wr(ADDR_ENDIAN, 32'h0);
    rd(ADDR_ENDIAN, BYTE_ORDER_PATTERN);
    bus(1'b1, 8'h1C, 32'hFFFFFFFF, q, e);
    chk("slverr", 1, e);
    bus(1'b0, 8'h00, 32'h0, q, e);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_timing;
    wr(ADDR_DATA_TIME, 32'hFFFFFFFF);
    rd(ADDR_DATA_TIME, DATA_TIME_RESET);
    cc(32'h3);
    chk("cce", 1, cce);
    wr(ADDR_DATA_TIME, 32'hFFFFFFFF);
    rd(ADDR_DATA_TIME, DATA_TIME_MASK);
    chk("tdc", 1, delay_compensation_enable);
    wr(ADDR_DATA_TIME, 32'h00000100);
    cc(32'h0);
    period(4, 3);
    cc(32'h1);
    cc(32'h3);
    wr(ADDR_DATA_TIME, 32'h00010210);
    cc(32'h0);
    period(12, 8);
    wr(ADDR_DATA_TIME, 32'h0);
    rd(ADDR_DATA_TIME, 32'h00010210);
  endtask
  task automatic t_test;
    wr(ADDR_TEST, 32'h70);
    rd(ADDR_TEST, 32'h0, 32'h7F);
    cc(32'h1);
    cc(32'h3);
    cc(32'h83);
    for (int m = 0; m < 4; m++) begin
      slow <= m[1];
      wr(ADDR_TEST, m << 5);
      repeat (8) @(posedge i_clock);
      chk("tx pin", m == 0 || m == 3, tx_pin);
      rd(ADDR_TEST, {m == 0 || m == 3, m[1:0], 5'h0}, 32'hFF);
    end
    // pin held recessive, so only the loop brings the dominant bit back
    wr(ADDR_TEST, 32'h70);
    i_core_tx_bit <= 1'b0;
    cc(32'h80);
    repeat (30) @(posedge i_clock);
    chk("loop back", 0, core_rx);
    chk("tx pin", 1, tx_pin);
    chk("init", 0, init);
    i_core_tx_bit <= 1'b1;
    cc(32'h1);
    cc(32'h3);
    rd(ADDR_TEST, 32'h0, 32'h7F);
  endtask
  task automatic t_watch;
    wr(ADDR_WATCHDOG, 32'h5);
    pulse(0);
    pulse(1);
    repeat (10) @(posedge i_clock);
    chk("flag", 0, flag);
    rd(ADDR_WATCHDOG, 32'h0505);
    pulse(0);
    repeat (10) @(posedge i_clock);
    chk("flag", 1, flag);
    rd(ADDR_WATCHDOG, 32'h00010005);
    wr(ADDR_WATCHDOG, 32'h00010000);
    pulse(0);
    repeat (10) @(posedge i_clock);
    chk("flag", 0, flag);
    rd(ADDR_WATCHDOG, 32'h0);
  endtask
  task automatic t_pause;
    cc(32'hC003);
    rd(ADDR_CORE_CTRL, 32'hC003);
    chk("fd format", 1, fmt);
    cc(32'hC000);
    pause_len(10, 26);
    cc(32'h1);
    cc(32'h3);
    cc(32'h3);
    cc(32'h0);
    pause_len(0, 0);
  endtask

  initial begin
    i_reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    i_core_tx_bit = 1'b1;
    i_tx_success = 1'b0;
    i_ram_access = 1'b0;
    i_ram_ready = 1'b0;
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    t_reset();
    t_regs();
    t_timing();
    t_test();
    t_watch();
    t_pause();
    conclude();
  end
endmodule
